/* File: hw/ecp_capture_pwm.sv */
// module: event capture unit with auxiliary pwm and axi4-lite registers
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ecp_capture_pwm (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output var  logic        s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output var  logic        s_axi_wready_out,
  output var  logic [1:0]  s_axi_bresp_out,
  output var  logic        s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output var  logic        s_axi_arready_out,
  output var  logic [31:0] s_axi_rdata_out,
  output var  logic [1:0]  s_axi_rresp_out,
  output var  logic        s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        capture_pin_in,
  output var  logic        capture_pin_out,
  output var  logic        capture_pin_oe_out,
  output var  logic        irq_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ecp_pkg::ecp_ctrl_t             ctrl;
  logic [31:0]                    counter;
  logic [31:0]                    stamp [0:3];
  logic [1:0]                     event_sequencer_count;
  logic                           armed;
  logic [ecp_pkg::INT_W-1:0]      status;
  logic [ecp_pkg::INT_W-1:0]      mask;
  logic                           pin_q;
  logic [5:0]                     div_cnt;
  logic                           div_sig;
  logic                           psig_q;
  logic [7:0]                     waddr_q;
  logic [31:0]                    wdata_q;
  logic [3:0]                     wstrb_q;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  logic do_write;
  assign do_write = !s_axi_awready_out && !s_axi_wready_out &&
                    !s_axi_bvalid_out;

  function automatic logic wr_at(input logic [7:0] ofs);
    return do_write && (waddr_q == ofs);
  endfunction : wr_at

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ecp_pkg::OFS_STATE);
  endfunction : mapped

  function automatic logic [31:0] wmerge(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_q[b]) begin
        r[8*b +: 8] = wdata_q[8*b +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // ----------------------------------------------------------------
  // aliases in pwm mode
  // ----------------------------------------------------------------
  logic [31:0] stamp1_active_period;
  logic [31:0] stamp2_active_compare;
  logic        pwm;
  assign stamp1_active_period  = stamp[0];
  assign stamp2_active_compare = stamp[1];
  assign pwm = ctrl.aux_pulse_width_mode;

  // ----------------------------------------------------------------
  // prescaler and edge qualification
  // ----------------------------------------------------------------
  logic psig;
  logic qual_edge;
  logic cap_event;
  logic stop_hit;
  logic counter_period_match;
  logic compare_match;
  logic rearm;

  assign psig = (ctrl.prescale == 5'h00) ? capture_pin_in : div_sig;
  assign qual_edge = ctrl.edge_fall[event_sequencer_count] ?
                     (!psig && psig_q) : (psig && !psig_q);
  assign cap_event = qual_edge && !pwm && ctrl.load_en &&
                     (armed || !ctrl.one_shot);
  assign stop_hit = ctrl.one_shot &&
                    (event_sequencer_count == ctrl.stop_value);
  assign counter_period_match = pwm && (counter == stamp1_active_period);
  assign compare_match = pwm && (counter == stamp2_active_compare);
  assign rearm = wr_at(ecp_pkg::OFS_REARM) && wstrb_q[0] && wdata_q[0];

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q   <= 1'b0;
      div_cnt <= ecp_pkg::DIV_RESET;
      div_sig <= 1'b0;
      psig_q  <= 1'b0;
    end else begin
      pin_q  <= capture_pin_in;
      psig_q <= psig;
      if (ctrl.prescale == 5'h00) begin
        div_cnt <= ecp_pkg::DIV_RESET;
      end else if (capture_pin_in != pin_q) begin
        if (div_cnt == {ctrl.prescale, 1'b0} - 6'h01) begin
          div_cnt <= ecp_pkg::DIV_RESET;
          div_sig <= !div_sig;
        end else begin
          div_cnt <= div_cnt + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // time base counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      counter <= ecp_pkg::CNT_RESET;
    end else if (wr_at(ecp_pkg::OFS_COUNTER)) begin
      counter <= wmerge(counter);
    end else if (cap_event && ctrl.cnt_rst[event_sequencer_count]) begin
      counter <= ecp_pkg::CNT_RESET;
    end else if (counter_period_match) begin
      counter <= ecp_pkg::CNT_RESET;
    end else begin
      counter <= counter + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // event sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_sequencer_count <= 2'h0;
      armed                 <= 1'b1;
    end else if (rearm) begin
      event_sequencer_count <= 2'h0;
      armed                 <= 1'b1;
    end else if (cap_event) begin
      if (stop_hit) begin
        armed <= 1'b0;
      end else begin
        event_sequencer_count <= event_sequencer_count + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // capture slots and shadow transfer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        stamp[i] <= ecp_pkg::CNT_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cap_event && (event_sequencer_count == 2'(i))) begin
          stamp[i] <= counter;
        end
      end
      if (counter_period_match && ctrl.shadow_on_prd) begin
        stamp[0] <= stamp[2];
        stamp[1] <= stamp[3];
      end
      if (wr_at(ecp_pkg::OFS_STAMP1)) begin
        stamp[0] <= wmerge(stamp[0]);
        if (pwm) begin
          stamp[2] <= wmerge(stamp[0]);
        end
      end
      if (wr_at(ecp_pkg::OFS_STAMP2)) begin
        stamp[1] <= wmerge(stamp[1]);
        if (pwm) begin
          stamp[3] <= wmerge(stamp[1]);
        end
      end
      if (wr_at(ecp_pkg::OFS_STAMP3)) begin
        stamp[2] <= wmerge(stamp[2]);
        if (pwm && !ctrl.shadow_on_prd) begin
          stamp[0] <= wmerge(stamp[2]);
        end
      end
      if (wr_at(ecp_pkg::OFS_STAMP4)) begin
        stamp[3] <= wmerge(stamp[3]);
        if (pwm && !ctrl.shadow_on_prd) begin
          stamp[1] <= wmerge(stamp[3]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_pin_out    <= 1'b0;
      capture_pin_oe_out <= 1'b0;
    end else begin
      capture_pin_oe_out <= pwm;
      capture_pin_out    <= pwm &&
        ((counter < stamp2_active_compare) ^ ctrl.pwm_pol);
    end
  end

  // ----------------------------------------------------------------
  // control, status and interrupt
  // ----------------------------------------------------------------
  logic [ecp_pkg::INT_W-1:0] evt;
  logic [ecp_pkg::INT_W-1:0] clr;
  always_comb begin
    evt = '0;
    for (int i = 0; i < 4; i++) begin
      evt[i] = cap_event && (event_sequencer_count == 2'(i));
    end
    evt[ecp_pkg::INT_OVF] = (counter == ecp_pkg::CNT_MAX);
    evt[ecp_pkg::INT_PRD] = counter_period_match;
    evt[ecp_pkg::INT_CMP] = compare_match;
    clr = '0;
    if (wr_at(ecp_pkg::OFS_STATUS) && wstrb_q[0]) begin
      clr = wdata_q[ecp_pkg::INT_W-1:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= ecp_pkg::CTRL_RESET;
    end else if (wr_at(ecp_pkg::OFS_CTRL)) begin
      ctrl <= ecp_pkg::ecp_ctrl_t'(
        ecp_pkg::CTRL_W'(wmerge(32'(ctrl))));
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status  <= '0;
      mask    <= '0;
      irq_out <= 1'b0;
    end else begin
      status  <= (status & ~clr) | evt;
      irq_out <= |(status & mask);
      if (wr_at(ecp_pkg::OFS_MASK)) begin
        mask <= ecp_pkg::INT_W'(wmerge(32'(mask)));
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= ecp_pkg::RESP_OKAY;
      waddr_q           <= 8'h00;
      wdata_q           <= 32'h00000000;
      wstrb_q           <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        waddr_q           <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wdata_q          <= s_axi_wdata_in;
        wstrb_q          <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= mapped(waddr_q) ? ecp_pkg::RESP_OKAY :
                                              ecp_pkg::RESP_SLV;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  logic [31:0] rd_val;
  always_comb begin
    unique case (s_axi_araddr_in)
      ecp_pkg::OFS_COUNTER: rd_val = counter;
      ecp_pkg::OFS_STAMP1:  rd_val = stamp[0];
      ecp_pkg::OFS_STAMP2:  rd_val = stamp[1];
      ecp_pkg::OFS_STAMP3:  rd_val = stamp[2];
      ecp_pkg::OFS_STAMP4:  rd_val = stamp[3];
      ecp_pkg::OFS_CTRL:    rd_val = 32'(ctrl);
      ecp_pkg::OFS_STATUS:  rd_val = 32'(status);
      ecp_pkg::OFS_MASK:    rd_val = 32'(mask);
      ecp_pkg::OFS_STATE:
        rd_val = {28'h0000000, capture_pin_in, armed,
                  event_sequencer_count};
      default:              rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= ecp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_val;
      s_axi_rresp_out   <= mapped(s_axi_araddr_in) ? ecp_pkg::RESP_OKAY :
                                                     ecp_pkg::RESP_SLV;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

endmodule : ecp_capture_pwm

`default_nettype wire

/* File: hw/ecp_pkg.sv */
// package: register map, control layout and constants of the capture unit
package ecp_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_COUNTER = 8'h00;
  localparam logic [7:0] OFS_STAMP1  = 8'h04;
  localparam logic [7:0] OFS_STAMP2  = 8'h08;
  localparam logic [7:0] OFS_STAMP3  = 8'h0C;
  localparam logic [7:0] OFS_STAMP4  = 8'h10;
  localparam logic [7:0] OFS_CTRL    = 8'h14;
  localparam logic [7:0] OFS_REARM   = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_MASK    = 8'h20;
  localparam logic [7:0] OFS_STATE   = 8'h24;

  // ----------------------------------------------------------------
  // control register layout, bit 0 first from the bottom
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       pwm_pol;
    logic       shadow_on_prd;
    logic [4:0] prescale;
    logic       load_en;
    logic [3:0] cnt_rst;
    logic [3:0] edge_fall;
    logic [1:0] stop_value;
    logic       one_shot;
    logic       aux_pulse_width_mode;
  } ecp_ctrl_t;

  localparam int        CTRL_W     = 20;
  localparam ecp_ctrl_t CTRL_RESET = 20'h01000;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int INT_W   = 7;
  localparam int INT_OVF = 4;
  localparam int INT_PRD = 5;
  localparam int INT_CMP = 6;

  localparam logic [31:0] CNT_RESET = 32'h00000000;
  localparam logic [31:0] CNT_MAX   = 32'hFFFFFFFF;
  localparam logic [5:0]  DIV_RESET = 6'h00;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;

endpackage : ecp_pkg

/* File: tb/ecp_capture_pwm_assertions.sv */
// checker: bus timing and pin properties of the capture unit
`timescale 1ns/1ps
`default_nettype none
module ecp_capture_pwm_assertions (
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  s_axi_awaddr_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [7:0]  s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        capture_pin_out,
  input wire logic        capture_pin_oe_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire logic aw_t = s_axi_awvalid_in && s_axi_awready_out;
  wire logic w_t  = s_axi_wvalid_in && s_axi_wready_out;
  wire logic ar_t = s_axi_arvalid_in && s_axi_arready_out;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_aw_block;
    aw_t |=> !s_axi_awready_out [*2];
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("awready high");
  property p_b_time;
    aw_t && w_t |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out;
  endproperty
  a_b_time: assert property (p_b_time) else $error("bvalid late");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("b dropped");
  property p_ready_back;
    s_axi_bvalid_out && s_axi_bready_in
      |=> s_axi_awready_out && s_axi_wready_out && !s_axi_bvalid_out;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("no reopen");
  property p_r_time;
    ar_t |=> s_axi_rvalid_out && !s_axi_arready_out;
  endproperty
  a_r_time: assert property (p_r_time) else $error("rvalid late");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("r dropped");
  property p_bad_rd;
    ar_t && s_axi_araddr_in > 8'h24
      |=> s_axi_rresp_out == ecp_pkg::RESP_SLV && s_axi_rdata_out == 0;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("bad read ok");
  property p_bad_wr;
    aw_t && w_t && s_axi_awaddr_in[1:0] != 2'h0
      |-> ##2 s_axi_bresp_out == ecp_pkg::RESP_SLV;
  endproperty
  a_bad_wr: assert property (p_bad_wr) else $error("bad write ok");
  property p_pin_idle;
    !capture_pin_oe_out |-> !capture_pin_out;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("pin driven");
  c_bad_rd: cover property (ar_t && s_axi_araddr_in > 8'h24);
  c_pwm: cover property (capture_pin_oe_out && $rose(capture_pin_out));
  c_wr: cover property (aw_t && w_t);
endmodule : ecp_capture_pwm_assertions
bind ecp_capture_pwm ecp_capture_pwm_assertions u_chk (.*);
`default_nettype wire

/* File: tb/ecp_capture_pwm_tb.sv */
// testbench: capture, one-shot, interrupt and pwm checks
`timescale 1ns/1ps
`default_nettype none
module ecp_capture_pwm_tb;
  typedef struct {
    logic [31:0] ctrl;
    int          hi;
    int          lo;
    logic [31:0] e [4];
  } ecp_row_t;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  s_axi_awaddr_in = 8'h00;
  logic        s_axi_awvalid_in = 1'b0;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic        s_axi_wvalid_in = 1'b0;
  logic        s_axi_bready_in = 1'b0;
  logic [7:0]  s_axi_araddr_in = 8'h00;
  logic        s_axi_arvalid_in = 1'b0;
  logic        s_axi_rready_in = 1'b0;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out, irq_out, drv;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, resp;
  logic [31:0] s_axi_rdata_out, rd;
  logic        capture_pin_out, capture_pin_oe_out;
  wire logic   capture_pin_in = capture_pin_oe_out ? capture_pin_out : drv;
  int          err_total = 0, total_checks = 0, hits, e;
  int          pw_cmp [6] = '{0, 3, 9, 10, 12, 3};
  logic [31:0] rst_v [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1000,
                            32'h0, 32'h0, 32'h0, 32'h4};
  ecp_row_t    rows [4];
  ecp_capture_pwm u_dut (.*);
  ecp_pin_src u_src (.clk_in(mclk_in), .drv_out(drv));
  always #20 mclk_in = ~mclk_in;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] x, g);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    resp = s_axi_bresp_out;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    rd = s_axi_rdata_out;
    resp = s_axi_rresp_out;
  endtask : rdr
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #2ms;
    err_total++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{32'h1F00, 3, 7, '{32'h9, 32'h9, 32'h9, 32'h9}};
    rows[1] = '{32'h1FF0, 3, 7, '{32'h9, 32'h9, 32'h9, 32'h9}};
    rows[2] = '{32'h1FA0, 3, 7, '{32'h6, 32'h2, 32'h6, 32'h2}};
    rows[3] = '{32'h3F00, 3, 7, '{32'h13, 32'h13, 32'h13, 32'h13}};
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdr(8'(4 * (i + 1)));
      chk("reset value", rst_v[i], rd);
    end
    rdr(8'h28);
    chk("read resp", 32'(ecp_pkg::RESP_SLV), 32'(resp));
    wr(8'h15, 32'hFFFFFFFF);
    chk("write resp", 32'(ecp_pkg::RESP_SLV), 32'(resp));
    rdr(ecp_pkg::OFS_CTRL);
    chk("ctrl kept", 32'h1000, rd);
    $display("reset test done");
    foreach (rows[r]) begin
      wr(ecp_pkg::OFS_CTRL, rows[r].ctrl);
      wr(ecp_pkg::OFS_REARM, 32'h1);
      u_src.pulses(12, rows[r].hi, rows[r].lo);
      for (int i = 0; i < 4; i++) begin
        rdr(8'(ecp_pkg::OFS_STAMP1 + 8'(4 * i)));
        chk("stamp", rows[r].e[i], rd);
      end
      $display("row %0d done", r);
    end
    wr(ecp_pkg::OFS_STATUS, 32'h7F);
    wr(ecp_pkg::OFS_CTRL, 32'h1006);
    wr(ecp_pkg::OFS_COUNTER, 32'hFFFFFFF0);
    wr(ecp_pkg::OFS_REARM, 32'h1);
    u_src.pulses(4, 3, 7);
    rdr(ecp_pkg::OFS_STATE);
    chk("one-shot state", 32'h1, rd);
    rdr(ecp_pkg::OFS_STAMP1);
    e = int'(rd);
    rdr(ecp_pkg::OFS_STAMP2);
    chk("absolute delta", 32'hA, rd - 32'(e));
    rdr(ecp_pkg::OFS_STATUS);
    chk("status", 32'h13, rd);
    chk("irq masked", 32'h0, 32'(irq_out));
    wr(ecp_pkg::OFS_MASK, 32'h2);
    repeat (2) @(posedge mclk_in);
    chk("irq on", 32'h1, 32'(irq_out));
    wr(ecp_pkg::OFS_STATUS, 32'h2);
    repeat (2) @(posedge mclk_in);
    chk("irq off", 32'h0, 32'(irq_out));
    wr(ecp_pkg::OFS_REARM, 32'h1);
    rdr(ecp_pkg::OFS_STATE);
    chk("rearmed", 32'h4, rd);
    $display("one-shot test done");
    wr(ecp_pkg::OFS_CTRL, 32'h1001);
    wr(ecp_pkg::OFS_COUNTER, 32'h0);
    wr(ecp_pkg::OFS_STAMP1, 32'h9);
    for (int k = 0; k < 6; k++) begin
      if (k == 5) wr(ecp_pkg::OFS_CTRL, 32'h81001);
      wr(ecp_pkg::OFS_STAMP2, 32'(pw_cmp[k]));
      rdr(ecp_pkg::OFS_STAMP4);
      chk("shadow copy", 32'(pw_cmp[k]), rd);
      repeat (30) @(posedge mclk_in);
      hits = 0;
      repeat (30) begin
        @(posedge mclk_in);
        hits += int'(capture_pin_in);
      end
      e = 3 * (pw_cmp[k] > 10 ? 10 : pw_cmp[k]);
      chk("high count", 32'(k == 5 ? 30 - e : e), 32'(hits));
    end
    chk("pin drive", 32'h1, 32'(capture_pin_oe_out));
    rdr(ecp_pkg::OFS_STAMP1);
    chk("period kept", 32'h9, rd);
    wr(ecp_pkg::OFS_STAMP4, 32'h5);
    rdr(ecp_pkg::OFS_STAMP2);
    chk("shadow now", 32'h5, rd);
    wr(ecp_pkg::OFS_CTRL, 32'h41001);
    wr(ecp_pkg::OFS_COUNTER, 32'h20);
    wr(ecp_pkg::OFS_STAMP3, 32'h40);
    rdr(ecp_pkg::OFS_STAMP1);
    chk("shadow held", 32'h9, rd);
    wr(ecp_pkg::OFS_COUNTER, 32'h0);
    repeat (12) @(posedge mclk_in);
    rdr(ecp_pkg::OFS_STAMP1);
    chk("shadow on match", 32'h40, rd);
    $display("pwm test done");
    rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    chk("oe after reset", 32'h0, 32'(capture_pin_oe_out));
    rdr(ecp_pkg::OFS_CTRL);
    chk("ctrl after reset", 32'h1000, rd);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule : ecp_capture_pwm_tb
`default_nettype wire

/* File: tb/ecp_pin_src.sv */
// partner: event source that drives the capture pin
`timescale 1ns/1ps
`default_nettype none
module ecp_pin_src (
  input  wire logic clk_in,
  output var  logic drv_out
);
  initial drv_out = 1'b0;
  // pulse train, always ends low
  task automatic pulses(input int cnt, input int hi, input int lo);
    repeat (cnt) begin
      drv_out <= 1'b1;
      repeat (hi) @(posedge clk_in);
      drv_out <= 1'b0;
      repeat (lo) @(posedge clk_in);
    end
  endtask : pulses
endmodule : ecp_pin_src
`default_nettype wire
